// *** rtl/asw_defines.svh ***
`ifndef ASW_DEFINES_SVH
`define ASW_DEFINES_SVH

// Register byte offsets
`define ASW_OFS_UPPER 8'h24
`define ASW_OFS_LOWER 8'h28
`define ASW_OFS_SLOTS_13_16 8'h2C
`define ASW_OFS_SLOTS_7_12 8'h30
`define ASW_OFS_SLOTS_1_6 8'h34
`define ASW_OFS_CTRL 8'h60
`define ASW_OFS_STATUS 8'h64
`define ASW_OFS_INT_EN 8'h68
`define ASW_OFS_INT_CLR 8'h6C

// Field widths and positions
`define ASW_LIMIT_W 12
`define ASW_SLOT_W 5
`define ASW_COUNT_LSB 20
`define ASW_CTRL_START 0
`define ASW_CTRL_CONT 1
`define ASW_CTRL_AWD_EN 2
`define ASW_CTRL_STOP 3
`define ASW_EV_AWD 0
`define ASW_EV_EOS 1
`define ASW_STS_BUSY 4
`define ASW_STS_POS_LSB 8
`define ASW_STS_LAST_LSB 16

// Reset value and highest channel number
`define ASW_RESET_WORD 32'h0000_0000
`define ASW_MAX_CHANNEL 5'h11

`endif

// *** rtl/asw_pkg.sv ***
package asw_pkg;

    typedef enum logic [0:0] {
        ASW_IDLE = 1'b0,
        ASW_CONV = 1'b1
    } asw_seq_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } asw_bus_t;

    typedef struct packed {
        logic done;
        logic [11:0] data;
    } asw_res_t;

    typedef struct packed {
        logic [11:0] upper_limit;
        logic [11:0] lower_bound;
        logic [3:0] count;
        logic [15:0][4:0] slot;
        logic cont;
        logic awd_en;
        asw_seq_t seq;
        logic [3:0] pos;
        logic req;
        logic [4:0] chan;
        logic [11:0] last;
        logic [1:0] sts;
        logic [1:0] ien;
        logic [31:0] rdata;
    } asw_state_t;

endpackage

// *** rtl/asw_regseq.sv ***
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "asw_defines.svh"

module asw_regseq
    import asw_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire asw_bus_t bus,
    output logic [31:0] rdata,
    output logic conv_req,
    output logic [4:0] conv_chan,
    input wire asw_res_t res,
    output logic irq
);

////////////////////////////////////////////////////////////////////////////////

    asw_state_t st_ff;
    asw_state_t nxt_st;
    logic [1:0] set_ev;
    logic [31:0] rd_word;
    logic seq_done;

    // Packs n consecutive slots starting at base into one word
    function automatic logic [29:0] asw_pack(
        input logic [15:0][4:0] s,
        input int base,
        input int n
    );
        logic [29:0] w;
        w = 30'h0000_0000;
        for (int i = 0; i < n; i++) begin
            w[5*i +: 5] = s[base + i];
        end
        return w;
    endfunction

    // Window check of a result against both limits
    function automatic logic asw_outside(
        input logic [11:0] d,
        input logic [11:0] hi,
        input logic [11:0] lo
    );
        return (d > hi) || (d < lo);
    endfunction

////////////////////////////////////////////////////////////////////////////////

    assign seq_done = (st_ff.pos == st_ff.count);

    always_comb begin
        nxt_st = st_ff;
        set_ev = 2'b00;
        rd_word = `ASW_RESET_WORD;

        if (bus.wr) begin
            case (bus.addr)
                `ASW_OFS_UPPER: begin
                    nxt_st.upper_limit = bus.wdata[`ASW_LIMIT_W-1:0];
                end
                `ASW_OFS_LOWER: begin
                    nxt_st.lower_bound = bus.wdata[`ASW_LIMIT_W-1:0];
                end
                `ASW_OFS_SLOTS_13_16: begin
                    nxt_st.count = bus.wdata[`ASW_COUNT_LSB +: 4];
                    for (int i = 0; i < 4; i++) begin
                        nxt_st.slot[12 + i] = bus.wdata[5*i +: `ASW_SLOT_W];
                    end
                end
                `ASW_OFS_SLOTS_7_12: begin
                    for (int i = 0; i < 6; i++) begin
                        nxt_st.slot[6 + i] = bus.wdata[5*i +: `ASW_SLOT_W];
                    end
                end
                `ASW_OFS_SLOTS_1_6: begin
                    // Top two bits are not stored, so they always read back as reset
                    for (int i = 0; i < 6; i++) begin
                        nxt_st.slot[i] = bus.wdata[5*i +: `ASW_SLOT_W];
                    end
                end
                `ASW_OFS_CTRL: begin
                    nxt_st.cont = bus.wdata[`ASW_CTRL_CONT];
                    nxt_st.awd_en = bus.wdata[`ASW_CTRL_AWD_EN];
                    // Start is ignored while a sequence runs, no restart mid-way
                    if (bus.wdata[`ASW_CTRL_START] && (st_ff.seq == ASW_IDLE)) begin
                        nxt_st.seq = ASW_CONV;
                        nxt_st.pos = 4'h0;
                        nxt_st.req = 1'b1;
                        nxt_st.chan = st_ff.slot[0];
                    end
                end
                `ASW_OFS_INT_EN: begin
                    nxt_st.ien = bus.wdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // Sequencer: one request per slot, held until the converter answers
        case (st_ff.seq)
            ASW_IDLE: begin
            end
            ASW_CONV: begin
                if (res.done) begin
                    nxt_st.last = res.data;
                    if (st_ff.awd_en && asw_outside(res.data, st_ff.upper_limit,
                                                    st_ff.lower_bound)) begin
                        set_ev[`ASW_EV_AWD] = 1'b1;
                    end
                    if (seq_done) begin
                        set_ev[`ASW_EV_EOS] = 1'b1;
                        nxt_st.pos = 4'h0;
                        nxt_st.chan = st_ff.slot[0];
                        // Continuous mode is sampled here, so clearing it ends the run cleanly
                        if (!nxt_st.cont) begin
                            nxt_st.seq = ASW_IDLE;
                            nxt_st.req = 1'b0;
                        end
                    end else begin
                        nxt_st.pos = st_ff.pos + 4'h1;
                        nxt_st.chan = st_ff.slot[st_ff.pos + 4'h1];
                    end
                end
            end
            default: begin
                nxt_st.seq = ASW_IDLE;
                nxt_st.req = 1'b0;
            end
        endcase

        // Stop aborts at once and wins over a completion in the same cycle
        if (bus.wr && (bus.addr == `ASW_OFS_CTRL) && bus.wdata[`ASW_CTRL_STOP]) begin
            nxt_st.seq = ASW_IDLE;
            nxt_st.req = 1'b0;
            nxt_st.pos = 4'h0;
        end

        // Sticky events: a new event beats a clear in the same cycle
        if (bus.wr && (bus.addr == `ASW_OFS_INT_CLR)) begin
            nxt_st.sts = st_ff.sts & ~bus.wdata[1:0];
        end
        nxt_st.sts = nxt_st.sts | set_ev;

        case (bus.addr)
            `ASW_OFS_UPPER: begin
                rd_word[`ASW_LIMIT_W-1:0] = st_ff.upper_limit;
            end
            `ASW_OFS_LOWER: begin
                rd_word[`ASW_LIMIT_W-1:0] = st_ff.lower_bound;
            end
            `ASW_OFS_SLOTS_13_16: begin
                rd_word[`ASW_COUNT_LSB +: 4] = st_ff.count;
                rd_word[19:0] = 20'(asw_pack(st_ff.slot, 12, 4));
            end
            `ASW_OFS_SLOTS_7_12: begin
                rd_word[29:0] = asw_pack(st_ff.slot, 6, 6);
            end
            `ASW_OFS_SLOTS_1_6: begin
                rd_word[29:0] = asw_pack(st_ff.slot, 0, 6);
            end
            `ASW_OFS_CTRL: begin
                rd_word[`ASW_CTRL_CONT] = st_ff.cont;
                rd_word[`ASW_CTRL_AWD_EN] = st_ff.awd_en;
            end
            `ASW_OFS_STATUS: begin
                rd_word[1:0] = st_ff.sts;
                rd_word[`ASW_STS_BUSY] = (st_ff.seq == ASW_CONV);
                rd_word[`ASW_STS_POS_LSB +: 4] = st_ff.pos;
                rd_word[`ASW_STS_LAST_LSB +: 12] = st_ff.last;
            end
            `ASW_OFS_INT_EN: begin
                rd_word[1:0] = st_ff.ien;
            end
            default: begin
            end
        endcase

        // Read data stand for exactly one cycle, zero otherwise
        nxt_st.rdata = bus.rd ? rd_word : `ASW_RESET_WORD;
    end

////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign conv_req = st_ff.req;
    assign conv_chan = st_ff.chan;
    assign irq = |(st_ff.sts & st_ff.ien);

////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_upper_write;
        bus.wr && (bus.addr == `ASW_OFS_UPPER)
        |=> st_ff.upper_limit == $past(bus.wdata[11:0]);
    endproperty
    a_upper_write: assert property (p_upper_write)
        else $error("upper limit not stored");

    property p_upper_read;
        bus.rd && (bus.addr == `ASW_OFS_UPPER)
        |=> (rdata[31:12] == 20'h0_0000) && (rdata[11:0] == $past(st_ff.upper_limit));
    endproperty
    a_upper_read: assert property (p_upper_read)
        else $error("upper limit read wrong");

    property p_lower_roundtrip;
        bus.wr && (bus.addr == `ASW_OFS_LOWER) ##1 bus.rd && (bus.addr == `ASW_OFS_LOWER)
        |=> rdata == {20'h0_0000, $past(bus.wdata[11:0], 2)};
    endproperty
    a_lower_roundtrip: assert property (p_lower_roundtrip)
        else $error("lower limit round trip wrong");

    property p_eos_at_count;
        (st_ff.seq == ASW_CONV) && res.done && (st_ff.pos == st_ff.count)
        |=> st_ff.sts[`ASW_EV_EOS] && (st_ff.pos == 4'h0);
    endproperty
    a_eos_at_count: assert property (p_eos_at_count)
        else $error("sequence end not at count code");

    property p_slot_field;
        bus.wr && (bus.addr == `ASW_OFS_SLOTS_1_6)
        |=> st_ff.slot[5] == $past(bus.wdata[29:25]);
    endproperty
    a_slot_field: assert property (p_slot_field)
        else $error("slot 6 field wrong");

    property p_first_read;
        bus.rd && (bus.addr == `ASW_OFS_SLOTS_13_16)
        |=> rdata == {8'h00, $past(st_ff.count), $past(st_ff.slot[15]),
                      $past(st_ff.slot[14]), $past(st_ff.slot[13]), $past(st_ff.slot[12])};
    endproperty
    a_first_read: assert property (p_first_read)
        else $error("first sequence register read wrong");

    property p_second_read;
        bus.rd && (bus.addr == `ASW_OFS_SLOTS_7_12)
        |=> (rdata[31:30] == 2'b00) && (rdata[4:0] == $past(st_ff.slot[6]))
            && (rdata[29:25] == $past(st_ff.slot[11]));
    endproperty
    a_second_read: assert property (p_second_read)
        else $error("second sequence register read wrong");

    property p_third_write;
        bus.wr && (bus.addr == `ASW_OFS_SLOTS_1_6)
        |=> (st_ff.slot[0] == $past(bus.wdata[4:0]))
            && (asw_pack(st_ff.slot, 0, 6) == $past(bus.wdata[29:0]));
    endproperty
    a_third_write: assert property (p_third_write)
        else $error("third sequence register not stored");

    property p_next_slot;
        (st_ff.seq == ASW_CONV) && res.done && (st_ff.pos != st_ff.count)
        && !(bus.wr && (bus.addr == `ASW_OFS_CTRL))
        |=> (st_ff.pos == $past(st_ff.pos) + 4'h1)
            // Slot taken before the edge, a slot write in that cycle lands later
            && (conv_chan == $past(st_ff.slot[st_ff.pos + 4'h1])) && conv_req;
    endproperty
    a_next_slot: assert property (p_next_slot)
        else $error("sequencer did not advance one slot");

    property p_single_stop;
        (st_ff.seq == ASW_CONV) && res.done && seq_done && !st_ff.cont && !bus.wr
        |=> !conv_req ##1 !conv_req;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single sequence did not stop");

    property p_watchdog;
        (st_ff.seq == ASW_CONV) && res.done && st_ff.awd_en
        && asw_outside(res.data, st_ff.upper_limit, st_ff.lower_bound)
        |=> st_ff.sts[`ASW_EV_AWD] && (irq == st_ff.ien[`ASW_EV_AWD] || st_ff.sts[1]);
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog event missed");

    c_start: cover property ((st_ff.seq == ASW_IDLE) ##1 (st_ff.seq == ASW_CONV));
    c_wrap: cover property (st_ff.cont && res.done && seq_done && (st_ff.seq == ASW_CONV));
    c_awd: cover property ($rose(st_ff.sts[`ASW_EV_AWD]));
    c_full: cover property ((st_ff.pos == 4'hF) && res.done);

endmodule

// *** tb/asw_regseq_tb_top.sv ***
`timescale 1ns/10ps
`include "asw_defines.svh"
module asw_regseq_tb_top
    import asw_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    asw_bus_t bus = '0;
    asw_res_t res = '0;
    logic [31:0] rdata;
    logic conv_req;
    logic [4:0] conv_chan;
    logic irq;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    logic pend = 1'b0;
    logic [31:0] rq[$];
    logic [16:0] cq[$];
    logic [4:0] s[16];
    logic [11:0] lastd;
    logic [11:0] wd[4] = '{12'h200, 12'h201, 12'h100, 12'h0FF};
    logic [31:0] v[5];
    logic [31:0] msk[5] = '{32'h0000_0FFF, 32'h0000_0FFF, 32'h00FF_FFFF, 32'h3FFF_FFFF,
        32'h3FFF_FFFF};
    always #25 clk = ~clk;
    asw_regseq asw_regseq_i (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
        .conv_req(conv_req), .conv_chan(conv_chan), .res(res), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask
    // Expected data is noted here; the monitor below compares it
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        rq.push_back(e);
    endtask
    task idle;
        @(posedge clk);
        bus <= '0;
    endtask
    task wait_idle;
        int i;
        repeat (2) @(posedge clk);
        for (i = 0; i < 400 && conv_req !== 1'b0; i++) @(posedge clk);
        chk({31'h0, conv_req}, 32'h0, "sequence did not end");
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (pend && rq.size() > 0) begin
            chk(rdata, rq.pop_front(), "read data");
        end else if (arst_n) begin
            chk(rdata, 32'h0000_0000, "rdata outside read");
        end
        pend = bus.rd;
    end
    // Converter stand-in: checks each issued channel, answers after 1 to 4 cycles
    initial begin
        int d;
        logic [16:0] e;
        forever begin
            @(posedge clk);
            if (conv_req === 1'b1) begin
                if (cq.size() == 0) begin
                    chk(32'h1, 32'h0, "conversion beyond sequence");
                end else begin
                    e = cq.pop_front();
                    chk({27'h0, conv_chan}, {27'h0, e[16:12]}, "channel");
                    d = $urandom_range(4, 1);
                    repeat (d) @(posedge clk);
                    res <= '{done: 1'b1, data: e[11:0]};
                    @(posedge clk);
                    res <= '0;
                end
            end
        end
    end
    task load_and_start(input logic [3:0] code, input logic [31:0] ctrl, input int rounds);
        int k;
        int r;
        for (k = 0; k < 16; k++) s[k] = 5'($urandom_range(17, 0));
        wr(`ASW_OFS_SLOTS_1_6, {2'b00, s[5], s[4], s[3], s[2], s[1], s[0]});
        wr(`ASW_OFS_SLOTS_7_12, {2'b00, s[11], s[10], s[9], s[8], s[7], s[6]});
        wr(`ASW_OFS_SLOTS_13_16, {8'h00, code, s[15], s[14], s[13], s[12]});
        for (r = 0; r < rounds; r++) begin
            for (k = 0; k <= code; k++) begin
                lastd = 12'($urandom_range(12'hFFF, 0));
                cq.push_back({s[k], lastd});
            end
        end
        wr(`ASW_OFS_CTRL, ctrl);
        idle();
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        void'($urandom(32'ha28c_c6c2));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        // Reset values of the five registers, back to back
        for (i = 0; i < 5; i++) rd(8'(8'h24 + 4 * i), 32'h0000_0000);
        // Random writes, then readback with reserved bits reading zero
        for (i = 0; i < 5; i++) begin
            v[i] = $urandom() & msk[i];
            wr(8'(8'h24 + 4 * i), (i == 4) ? v[i] : ($urandom() & ~msk[i]) | v[i]);
        end
        wr(8'h40, 32'hFFFF_FFFF);
        for (i = 0; i < 5; i++) rd(8'(8'h24 + 4 * i), v[i]);
        rd(8'h40, 32'h0000_0000);
        idle();
        // Every length code; interrupt enabled on odd codes only
        for (i = 0; i < 16; i++) begin
            wr(`ASW_OFS_INT_EN, {30'h0, 1'(i), 1'b0});
            load_and_start(4'(i), 32'h0000_0001, 1);
            wait_idle();
            chk(cq.size(), 0, "slots left unconverted");
            chk({31'h0, irq}, {31'h0, 1'(i)}, "irq after sequence end");
            rd(`ASW_OFS_STATUS, {4'h0, lastd, 14'h0, 2'b10});
            wr(`ASW_OFS_INT_CLR, 32'h0000_0003);
            idle();
            @(posedge clk);
            chk({31'h0, irq}, 32'h0, "irq after clear");
        end
        // Watchdog window: equal to a limit does not fire, one step outside does
        wr(`ASW_OFS_UPPER, 32'h0000_0200);
        wr(`ASW_OFS_LOWER, 32'h0000_0100);
        rd(`ASW_OFS_LOWER, 32'h0000_0100);
        wr(`ASW_OFS_INT_EN, 32'h0000_0001);
        for (i = 0; i < 4; i++) begin
            load_and_start(4'h0, 32'h0000_0005, 0);
            cq.push_back({s[0], wd[i]});
            wait_idle();
            chk({31'h0, irq}, {31'h0, 1'(i)}, "watchdog irq");
            rd(`ASW_OFS_STATUS, {4'h0, wd[i], 14'h0, 1'b1, 1'(i)});
            wr(`ASW_OFS_INT_CLR, 32'h0000_0003);
            idle();
        end
        // Continuous mode wraps to slot 1; a third round is queued but cut by stop
        load_and_start(4'h2, 32'h0000_0003, 3);
        for (i = 0; i < 600 && cq.size() > 3; i++) @(posedge clk);
        wr(`ASW_OFS_CTRL, 32'h0000_0008);
        idle();
        wait_idle();
        chk({31'h0, cq.size() <= 3}, 32'h1, "wrap did not occur");
        cq.delete();
        repeat (4) @(posedge clk);
        give_verdict();
    end
endmodule
